// *** logic/dwc_pkg.sv ***
// shared constants, types and code-alignment helpers for the converter control block
`default_nettype none
package dwc_pkg;

	// register word and converter code widths
	localparam int REG_W = 16;
	localparam int CODE_W = 12;
	localparam int ADDR_W = 3;

	// register offsets
	localparam logic [2:0] OFS_CTRL = 3'h0;
	localparam logic [2:0] OFS_DATA = 3'h1;
	localparam logic [2:0] OFS_STEP = 3'h2;
	localparam logic [2:0] OFS_LOWER = 3'h3;
	localparam logic [2:0] OFS_UPPER = 3'h4;

	// control register field positions
	localparam int CTRL_PDN_BIT = 0;
	localparam int CTRL_FMT_BIT = 1;
	localparam int CTRL_SEL_BIT = 2;
	localparam int CTRL_AUTO_BIT = 3;
	localparam int CTRL_UP_BIT = 4;
	localparam int CTRL_DOWN_BIT = 5;
	localparam int CTRL_HOLD_EN_BIT = 6;
	localparam int CTRL_HOLD_CNT_LSB = 8;
	localparam int HOLD_CNT_W = 6;
	localparam logic [15:0] CTRL_WMASK = 16'h3F7F;

	// reset values
	localparam logic [15:0] CTRL_RST = 16'h0001;
	localparam logic [15:0] DATA_RST = 16'h0000;
	localparam logic [15:0] STEP_RST = 16'h0000;
	localparam logic [15:0] LOWER_RST = 16'h0000;
	localparam logic [15:0] UPPER_RST = 16'hFFFF;

	// justification layout
	localparam int LEFT_LSB = 4;
	localparam logic [15:0] MASK_LEFT = 16'hFFF0;
	localparam logic [15:0] MASK_RIGHT = 16'h0FFF;

	// queue depth in front of the data register
	localparam int FIFO_DEPTH = 16;

	// glitch-hold sequencer states
	typedef enum logic [0:0] {
		ST_IDLE = 1'b0,
		ST_HOLD = 1'b1
	} dwc_hold_st_t;

	// bits of a register that carry the code in the chosen format
	function automatic logic [15:0] fmt_mask(input logic left);
		fmt_mask = left ? MASK_LEFT : MASK_RIGHT;
	endfunction : fmt_mask

	// pull the aligned 12-bit code out of a register word
	function automatic logic [11:0] code_of(input logic [15:0] raw, input logic left);
		code_of = left ? raw[15:4] : raw[11:0];
	endfunction : code_of

	// place a 12-bit code into a register word
	function automatic logic [15:0] raw_of(input logic [11:0] code, input logic left);
		raw_of = left ? {code, 4'h0} : {4'h0, code};
	endfunction : raw_of

endpackage : dwc_pkg
`default_nettype wire

// *** logic/dwc_stream_if.sv ***
// valid/ready stream carrier between the control core and its word queue
`timescale 1ns/100ps
`default_nettype none
interface dwc_stream_if #(parameter int W = 16);
	logic push_valid;
	logic push_ready;
	logic [W-1:0] push_data;
	logic pop_valid;
	logic pop_ready;
	logic [W-1:0] pop_data;

	// queue side
	modport fifo (
		input push_valid, push_data, pop_ready,
		output push_ready, pop_valid, pop_data
	);

	// user side
	modport user (
		output push_valid, push_data, pop_ready,
		input push_ready, pop_valid, pop_data
	);
endinterface : dwc_stream_if
`default_nettype wire

// *** logic/dwc_fifo.sv ***
// parameterised word queue with valid/ready on both sides
`timescale 1ns/100ps
`default_nettype none
module dwc_fifo #(
	parameter int W = 16,
	parameter int DEPTH = 16
) (
	// clock and reset
	input wire logic clk_sys,
	input wire logic nrst,
	// stream
	dwc_stream_if.fifo s
);
	localparam int AW = $clog2(DEPTH);

	// refuse depths the pointer logic cannot serve
	generate
		if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_bad_depth
			$error("dwc_fifo: DEPTH must be a power of two, at least 2");
		end
	endgenerate

	logic [W-1:0] mem [DEPTH];
	logic [AW-1:0] wr_ptr_q;
	logic [AW-1:0] rd_ptr_q;
	logic [AW:0] count_q;
	logic do_push;
	logic do_pop;

	// honest full and empty from the occupancy count
	assign s.push_ready = (count_q != (AW+1)'(DEPTH));
	assign s.pop_valid = (count_q != '0);
	assign s.pop_data = mem[rd_ptr_q];
	assign do_push = s.push_valid & s.push_ready;
	assign do_pop = s.pop_valid & s.pop_ready;

	// storage write
	always_ff @(posedge clk_sys) begin
		if (do_push) begin
			mem[wr_ptr_q] <= s.push_data;
		end
	end

	// pointers and occupancy
	always_ff @(posedge clk_sys) begin
		if (!nrst) begin
			wr_ptr_q <= '0;
			rd_ptr_q <= '0;
			count_q <= '0;
		end else begin
			if (do_push) begin
				wr_ptr_q <= wr_ptr_q + 1'b1;
			end
			if (do_pop) begin
				rd_ptr_q <= rd_ptr_q + 1'b1;
			end
			if (do_push && !do_pop) begin
				count_q <= count_q + 1'b1;
			end else if (do_pop && !do_push) begin
				count_q <= count_q - 1'b1;
			end
		end
	end

endmodule : dwc_fifo
`default_nettype wire

// *** logic/dwc_dac_ctrl.sv ***
// digital control in front of a 12-bit converter: data path, waveform generator, glitch hold
`timescale 1ns/100ps
`default_nettype none
module dwc_dac_ctrl #(
	parameter int FIFO_DEPTH = dwc_pkg::FIFO_DEPTH
) (
	// clock and reset
	input wire logic clk_sys,
	input wire logic nrst,
	// register port
	input wire logic reg_sel,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [2:0] reg_addr,
	input wire logic [15:0] reg_wdata,
	output logic [15:0] reg_rdata,
	output logic reg_wready,
	// update strobe from timer or comparator
	input wire logic sync_in,
	// converter side
	output logic [11:0] dac_code,
	output logic dac_update,
	output logic dac_power_down
);

	// refuse a queue the core cannot use
	generate
		if (FIFO_DEPTH < 2) begin : g_bad_fifo
			$error("dwc_dac_ctrl: FIFO_DEPTH must be at least 2");
		end
	endgenerate

	// registers
	logic [15:0] ctrl_q;
	logic [15:0] data_q;
	logic [15:0] step_q;
	logic [15:0] lower_q;
	logic [15:0] upper_q;
	logic [15:0] rdata_q;

	// control fields
	logic power_down_bit;
	logic format_left;
	logic strobe_sel;
	logic auto_mode;
	logic up_en;
	logic down_en;
	logic glitch_hold_enable;
	logic [5:0] glitch_hold_count;

	// strobe synchroniser and edge detect
	logic sync_meta_q;
	logic sync_stab_q;
	logic sync_last_q;
	logic strobe;

	// register access decode
	logic wr_ctrl;
	logic wr_data;
	logic wr_step;
	logic wr_lower;
	logic wr_upper;
	logic up_rise;
	logic down_rise;

	// aligned codes
	logic [11:0] data_code;
	logic [11:0] step_code;
	logic [11:0] lower_code;
	logic [11:0] upper_code;

	// waveform generator
	logic dir_up_q;
	logic step_dir;
	logic [11:0] step_val;
	logic [12:0] sum_up;
	logic [12:0] sum_down;

	// update scheduling
	logic hold_busy;
	logic pop_ok;
	logic pop_take;
	logic step_ev;
	logic reuse_ev;
	logic new_valid;
	logic [11:0] new_raw;
	logic [11:0] new_code;

	// glitch hold sequencer
	dwc_pkg::dwc_hold_st_t st_q;
	logic [6:0] hold_cnt_q;
	logic [11:0] pend_q;
	logic [11:0] dac_code_q;
	logic dac_update_q;

	// queue in front of the data register
	dwc_stream_if #(.W(dwc_pkg::REG_W)) q_if ();

	dwc_fifo #(
		.W(dwc_pkg::REG_W),
		.DEPTH(FIFO_DEPTH)
	) u_fifo (
		.clk_sys(clk_sys),
		.nrst(nrst),
		.s(q_if.fifo)
	);

	// clamp a code into the programmed window
	function automatic logic [11:0] clamp_code(input logic [11:0] v, input logic [11:0] lo,
		input logic [11:0] hi);
		if (v > hi) begin
			clamp_code = hi;
		end else if (v < lo) begin
			clamp_code = lo;
		end else begin
			clamp_code = v;
		end
	endfunction : clamp_code

	// control field extraction
	assign power_down_bit = ctrl_q[dwc_pkg::CTRL_PDN_BIT];
	assign format_left = ctrl_q[dwc_pkg::CTRL_FMT_BIT];
	assign strobe_sel = ctrl_q[dwc_pkg::CTRL_SEL_BIT];
	assign auto_mode = ctrl_q[dwc_pkg::CTRL_AUTO_BIT];
	assign up_en = ctrl_q[dwc_pkg::CTRL_UP_BIT];
	assign down_en = ctrl_q[dwc_pkg::CTRL_DOWN_BIT];
	assign glitch_hold_enable = ctrl_q[dwc_pkg::CTRL_HOLD_EN_BIT];
	assign glitch_hold_count =
		ctrl_q[dwc_pkg::CTRL_HOLD_CNT_LSB +: dwc_pkg::HOLD_CNT_W];

	// codes taken per the current justification
	assign data_code = dwc_pkg::code_of(data_q, format_left);
	assign step_code = dwc_pkg::code_of(step_q, format_left);
	assign lower_code = dwc_pkg::code_of(lower_q, format_left);
	assign upper_code = dwc_pkg::code_of(upper_q, format_left);

	// two-flop synchroniser, third flop for the edge only
	always_ff @(posedge clk_sys) begin
		if (!nrst) begin
			sync_meta_q <= 1'b0;
			sync_stab_q <= 1'b0;
			sync_last_q <= 1'b0;
		end else begin
			sync_meta_q <= sync_in;
			sync_stab_q <= sync_meta_q;
			sync_last_q <= sync_stab_q;
		end
	end

	// one pulse per rising edge; source keeps each level a cycle or more
	assign strobe = sync_stab_q & ~sync_last_q;

	// write decode
	assign wr_ctrl = reg_sel & reg_wr & (reg_addr == dwc_pkg::OFS_CTRL);
	assign wr_data = reg_sel & reg_wr & (reg_addr == dwc_pkg::OFS_DATA);
	assign wr_step = reg_sel & reg_wr & (reg_addr == dwc_pkg::OFS_STEP);
	assign wr_lower = reg_sel & reg_wr & (reg_addr == dwc_pkg::OFS_LOWER);
	assign wr_upper = reg_sel & reg_wr & (reg_addr == dwc_pkg::OFS_UPPER);
	assign up_rise = wr_ctrl & reg_wdata[dwc_pkg::CTRL_UP_BIT] & ~up_en;
	assign down_rise = wr_ctrl & reg_wdata[dwc_pkg::CTRL_DOWN_BIT] & ~down_en;

	// data writes queue up; a full queue back-pressures the writer
	assign q_if.push_valid = wr_data;
	assign q_if.push_data = reg_wdata & dwc_pkg::fmt_mask(format_left);
	assign reg_wready = q_if.push_ready;

	// control register
	always_ff @(posedge clk_sys) begin
		if (!nrst) begin
			ctrl_q <= dwc_pkg::CTRL_RST;
		end else if (wr_ctrl) begin
			ctrl_q <= reg_wdata & dwc_pkg::CTRL_WMASK;
		end
	end

	// step and limit registers, stored in the layout of the write
	always_ff @(posedge clk_sys) begin
		if (!nrst) begin
			step_q <= dwc_pkg::STEP_RST;
			lower_q <= dwc_pkg::LOWER_RST;
			upper_q <= dwc_pkg::UPPER_RST;
		end else begin
			if (wr_step) begin
				step_q <= reg_wdata & dwc_pkg::fmt_mask(format_left);
			end
			if (wr_lower) begin
				lower_q <= reg_wdata & dwc_pkg::fmt_mask(format_left);
			end
			if (wr_upper) begin
				upper_q <= reg_wdata & dwc_pkg::fmt_mask(format_left);
			end
		end
	end

	// next generator value; a step landing on or past a limit stops there
	always_comb begin
		sum_up = {1'b0, data_code} + {1'b0, step_code};
		sum_down = {1'b0, data_code} - {1'b0, step_code};
		step_dir = dir_up_q;
		step_val = data_code;
		if (dir_up_q) begin
			if (data_code >= upper_code) begin
				if (down_en) begin
					step_dir = 1'b0;
					if (sum_down[12] || sum_down[11:0] <= lower_code) begin
						step_val = lower_code;
					end else begin
						step_val = sum_down[11:0];
					end
				end else begin
					step_val = lower_code;
				end
			end else if (sum_up >= {1'b0, upper_code}) begin
				step_val = upper_code;
			end else begin
				step_val = sum_up[11:0];
			end
		end else begin
			if (data_code <= lower_code) begin
				if (up_en) begin
					step_dir = 1'b1;
					if (sum_up >= {1'b0, upper_code}) begin
						step_val = upper_code;
					end else begin
						step_val = sum_up[11:0];
					end
				end else begin
					step_val = upper_code;
				end
			end else if (sum_down[12] || sum_down[11:0] <= lower_code) begin
				step_val = lower_code;
			end else begin
				step_val = sum_down[11:0];
			end
		end
	end

	// update scheduling: what may reach the converter this cycle
	assign hold_busy = (st_q == dwc_pkg::ST_HOLD);
	always_comb begin
		if (hold_busy) begin
			pop_ok = 1'b0;
		end else if (auto_mode) begin
			pop_ok = 1'b1;
		end else if (strobe_sel) begin
			pop_ok = strobe;
		end else begin
			pop_ok = 1'b1;
		end
	end
	assign q_if.pop_ready = pop_ok;
	assign pop_take = q_if.pop_valid & pop_ok;
	assign step_ev = auto_mode & strobe & ~power_down_bit & ~hold_busy & ~pop_take;
	assign reuse_ev = ~auto_mode & strobe_sel & strobe & ~hold_busy & ~pop_take;
	assign new_valid = pop_take | step_ev | reuse_ev;

	// code handed to the glitch hold, clamped to the window in automatic mode
	always_comb begin
		if (pop_take) begin
			new_raw = dwc_pkg::code_of(q_if.pop_data, format_left);
		end else if (step_ev) begin
			new_raw = step_val;
		end else begin
			new_raw = data_code;
		end
		if (auto_mode) begin
			new_code = clamp_code(new_raw, lower_code, upper_code);
		end else begin
			new_code = new_raw;
		end
	end

	// buffered data register: loaded from the queue or by the generator
	always_ff @(posedge clk_sys) begin
		if (!nrst) begin
			data_q <= dwc_pkg::DATA_RST;
		end else if (pop_take) begin
			data_q <= q_if.pop_data;
		end else if (step_ev) begin
			data_q <= dwc_pkg::raw_of(step_val, format_left);
		end
	end

	// count direction: generator turns, software's last set bit wins, up when both bits rise in one write
	always_ff @(posedge clk_sys) begin
		if (!nrst) begin
			dir_up_q <= 1'b1;
		end else if (up_rise) begin
			dir_up_q <= 1'b1;
		end else if (down_rise) begin
			dir_up_q <= 1'b0;
		end else if (step_ev) begin
			dir_up_q <= step_dir;
		end
	end

	// glitch hold: park the new code for 2 * count + 1 cycles, then apply
	always_ff @(posedge clk_sys) begin
		if (!nrst) begin
			st_q <= dwc_pkg::ST_IDLE;
			hold_cnt_q <= '0;
			pend_q <= '0;
		end else begin
			unique case (st_q)
				dwc_pkg::ST_IDLE: begin
					if (new_valid && glitch_hold_enable) begin
						pend_q <= new_code;
						hold_cnt_q <= {glitch_hold_count, 1'b1};
						st_q <= dwc_pkg::ST_HOLD;
					end
				end
				dwc_pkg::ST_HOLD: begin
					hold_cnt_q <= hold_cnt_q - 7'h01;
					if (hold_cnt_q == 7'h01) begin
						st_q <= dwc_pkg::ST_IDLE;
					end
				end
			endcase
		end
	end

	// converter input and its update pulse
	always_ff @(posedge clk_sys) begin
		if (!nrst) begin
			dac_code_q <= '0;
			dac_update_q <= 1'b0;
		end else begin
			dac_update_q <= 1'b0;
			if (hold_busy && hold_cnt_q == 7'h01) begin
				dac_code_q <= pend_q;
				dac_update_q <= 1'b1;
			end else if (!hold_busy && new_valid && !glitch_hold_enable) begin
				dac_code_q <= new_code;
				dac_update_q <= 1'b1;
			end
		end
	end

	// registered read data; unmapped offsets read zero
	always_ff @(posedge clk_sys) begin
		if (!nrst) begin
			rdata_q <= '0;
		end else if (reg_sel && reg_rd) begin
			unique case (reg_addr)
				dwc_pkg::OFS_CTRL: rdata_q <= ctrl_q;
				dwc_pkg::OFS_DATA: rdata_q <= data_q & dwc_pkg::fmt_mask(format_left);
				dwc_pkg::OFS_STEP: rdata_q <= step_q & dwc_pkg::fmt_mask(format_left);
				dwc_pkg::OFS_LOWER: rdata_q <= lower_q & dwc_pkg::fmt_mask(format_left);
				dwc_pkg::OFS_UPPER: rdata_q <= upper_q & dwc_pkg::fmt_mask(format_left);
				default: rdata_q <= '0;
			endcase
		end
	end

	// outputs; power-down is a plain level, no interrupt line exists
	assign reg_rdata = rdata_q;
	assign dac_code = dac_code_q;
	assign dac_update = dac_update_q;
	assign dac_power_down = power_down_bit;

endmodule : dwc_dac_ctrl
`default_nettype wire

// *** testbench/dwc_dac_ctrl_assertions.sv ***
// concurrent checks on the converter control ports
`timescale 1ns/100ps
`default_nettype none
module dwc_dac_ctrl_assertions (
	// clock and reset
	input wire logic clk_sys,
	input wire logic nrst,
	// register port
	input wire logic reg_sel,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [2:0] reg_addr,
	input wire logic [15:0] reg_wdata,
	input wire logic [15:0] reg_rdata,
	input wire logic reg_wready,
	// strobe and converter side
	input wire logic sync_in,
	input wire logic [11:0] dac_code,
	input wire logic dac_update,
	input wire logic dac_power_down
);
	logic [15:0] ctl_q, lo_q, up_q;
	logic [11:0] wc_q, lo_c, hi_c;
	logic wr, rd;
	default clocking cb @(posedge clk_sys); endclocking
	// access strobes and limit codes in the current format
	assign wr = reg_sel && reg_wr;
	assign rd = reg_sel && reg_rd;
	assign lo_c = ctl_q[1] ? lo_q[15:4] : lo_q[11:0];
	assign hi_c = ctl_q[1] ? up_q[15:4] : up_q[11:0];
	// register shadow, masked by the format at write time
	always_ff @(posedge clk_sys) begin
		if (!nrst) begin
			ctl_q <= dwc_pkg::CTRL_RST;
			lo_q <= dwc_pkg::LOWER_RST;
			up_q <= dwc_pkg::UPPER_RST;
			wc_q <= 12'h000;
		end else if (wr) begin
			if (reg_addr == 3'h0) ctl_q <= reg_wdata & dwc_pkg::CTRL_WMASK;
			if (reg_addr == 3'h3) lo_q <= reg_wdata & dwc_pkg::fmt_mask(ctl_q[1]);
			if (reg_addr == 3'h4) up_q <= reg_wdata & dwc_pkg::fmt_mask(ctl_q[1]);
			if (reg_addr == 3'h1) wc_q <= ctl_q[1] ? reg_wdata[15:4] : reg_wdata[11:0];
		end
	end
	a_reset_quiet:
		assert property (!nrst |=> dac_code == 12'h000 && !dac_update && dac_power_down)
		else $error("outputs not at reset level");
	a_pdn_follow:
		assert property (disable iff (!nrst) dac_power_down == ctl_q[0])
		else $error("power-down output differs from control");
	a_code_moves:
		assert property (disable iff (!nrst) $changed(dac_code) |-> dac_update)
		else $error("code changed without update pulse");
	a_unmapped_zero:
		assert property (disable iff (!nrst) rd && reg_addr > 3'h4 |=> reg_rdata == 16'h0000)
		else $error("unmapped read not zero");
	a_upper_left:
		assert property (disable iff (!nrst) rd && reg_addr == 3'h4 && ctl_q[1]
			|=> reg_rdata == (up_q & 16'hFFF0))
		else $error("upper limit left read wrong");
	a_upper_right:
		assert property (disable iff (!nrst) rd && reg_addr == 3'h4 && !ctl_q[1]
			|=> reg_rdata == (up_q & 16'h0FFF))
		else $error("upper limit right read wrong");
	a_ctrl_back:
		assert property (disable iff (!nrst) rd && reg_addr == 3'h0 |=> reg_rdata == ctl_q)
		else $error("control read wrong");
	a_async_apply:
		assert property (disable iff (!nrst) wr && reg_addr == 3'h1 && reg_wready
			&& ctl_q[3:2] == 2'h0 && !ctl_q[6] |-> ##[1:4] (dac_update && dac_code == wc_q))
		else $error("async write not applied");
	a_sync_quiet:
		assert property (disable iff (!nrst) (ctl_q[2] && !ctl_q[3] && !sync_in)[*6]
			|-> !dac_update)
		else $error("sync mode update without strobe");
	a_auto_clamp:
		assert property (disable iff (!nrst) dac_update && ctl_q[3]
			|-> dac_code <= hi_c && dac_code >= lo_c)
		else $error("auto code outside limits");
endmodule : dwc_dac_ctrl_assertions
bind dwc_dac_ctrl dwc_dac_ctrl_assertions i_dwc_dac_ctrl_assertions (.clk_sys, .nrst, .reg_sel,
	.reg_wr, .reg_rd, .reg_addr, .reg_wdata, .reg_rdata, .reg_wready, .sync_in, .dac_code,
	.dac_update, .dac_power_down);
`default_nettype wire

// *** testbench/dwc_strobe_src.sv ***
// update strobe source standing in for a timer or comparator
`timescale 1ns/100ps
`default_nettype none
module dwc_strobe_src (
	// clock
	input wire logic clk_sys,
	// command from the bench
	input wire logic fire,
	input wire logic [3:0] hi_len,
	// strobe pin and state
	output logic sync_in,
	output logic busy
);
	logic [4:0] cnt_q = 5'h00;
	// high for hi_len cycles, then low four cycles or more before another pulse
	always_ff @(posedge clk_sys) begin
		if (fire && cnt_q == 5'h00) cnt_q <= {1'b0, hi_len} + 5'h03;
		else if (cnt_q != 5'h00) cnt_q <= cnt_q - 5'h01;
	end
	assign sync_in = cnt_q > 5'h03;
	assign busy = cnt_q != 5'h00;
endmodule : dwc_strobe_src
`default_nettype wire

// *** testbench/dwc_dac_ctrl_bench.sv ***
// self-checking bench for the converter control block
`timescale 1ns/100ps
`default_nettype none
module dwc_dac_ctrl_bench;
	logic clk_sys, nrst, reg_sel, reg_wr, reg_rd, fire, sync_in, busy;
	logic reg_wready, dac_update, dac_power_down;
	logic [2:0] reg_addr;
	logic [15:0] reg_wdata, reg_rdata;
	logic [11:0] dac_code;
	logic [3:0] hi_len;
	int fails = 0, comparisons = 0, cyc = 0, lat0, n;
	// design and strobe source
	dwc_dac_ctrl i_dwc_dac_ctrl (.clk_sys, .nrst, .reg_sel, .reg_wr, .reg_rd, .reg_addr,
		.reg_wdata, .reg_rdata, .reg_wready, .sync_in, .dac_code, .dac_update, .dac_power_down);
	dwc_strobe_src i_dwc_strobe_src (.clk_sys, .fire, .hi_len, .sync_in, .busy);
	// clock
	initial begin
		clk_sys = 1'b0;
		forever #2 clk_sys = ~clk_sys;
	end
	task automatic summarize;
		$display("%0d comparisons, %0d fails", comparisons, fails);
		if (fails == 0 && comparisons > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask : summarize
	task automatic chk(input logic [15:0] g, input logic [15:0] e);
		comparisons++;
		if (g !== e) begin
			fails++;
			$display("[ERR] %0t got %h want %h", $time, g, e);
		end
	endtask : chk
	task automatic wr(input logic [2:0] a, input logic [15:0] d);
		@(negedge clk_sys);
		{reg_sel, reg_wr, reg_addr, reg_wdata} = {2'b11, a, d};
		@(negedge clk_sys);
		{reg_sel, reg_wr} = 2'b00;
	endtask : wr
	task automatic rd(input logic [2:0] a, input logic [15:0] e);
		@(negedge clk_sys);
		{reg_sel, reg_rd, reg_addr} = {2'b11, a};
		@(negedge clk_sys);
		{reg_sel, reg_rd} = 2'b00;
		@(negedge clk_sys);
		chk(reg_rdata, e);
	endtask : rd
	// cycles until the next update pulse, 20 when none comes
	task automatic wait_upd(output int c);
		for (c = 0; c < 20 && dac_update !== 1'b1; c++) @(negedge clk_sys);
	endtask : wait_upd
	// one strobe, long and short in turn; quiet means no update expected
	task automatic stb(input logic [11:0] e, input logic quiet);
		@(negedge clk_sys);
		fire = 1'b1;
		hi_len = hi_len ^ 4'h4;
		@(negedge clk_sys);
		fire = 1'b0;
		wait_upd(n);
		chk({3'h0, n < 20, dac_code}, {3'h0, !quiet, e});
		while (busy) @(negedge clk_sys);
	endtask : stb
	task automatic t_regs;
		rd(3'h0, 16'h0001);
		rd(3'h1, 16'h0000);
		rd(3'h4, 16'h0FFF);
		rd(3'h7, 16'h0000);
		wr(3'h0, 16'hFFFF);
		rd(3'h0, 16'h3F7F);
		rd(3'h4, 16'hFFF0);
		wr(3'h4, 16'hABCD);
		rd(3'h4, 16'hABC0);
		$display("register test done");
	endtask : t_regs
	task automatic t_async;
		wr(3'h0, 16'h0000);
		wr(3'h1, 16'h0123);
		wait_upd(lat0);
		chk({4'h0, dac_code}, 16'h0123);
		wr(3'h0, 16'h0340);
		wr(3'h1, 16'h0456);
		wait_upd(n);
		chk(16'(n - lat0), 16'h0007);
		chk({4'h0, dac_code}, 16'h0456);
		$display("async and hold test done");
	endtask : t_async
	task automatic t_fifo;
		wr(3'h0, 16'h0004);
		for (int i = 0; i < 16; i++) wr(3'h1, 16'h0100 + 16'(i));
		chk({15'h0, reg_wready}, 16'h0000);
		chk({4'h0, dac_code}, 16'h0456);
		wr(3'h1, 16'h0FFF);
		for (int i = 0; i < 16; i++) stb(12'h100 + 12'(i), 1'b0);
		chk({15'h0, reg_wready}, 16'h0001);
		stb(12'h10F, 1'b0);
		$display("sync and queue test done");
	endtask : t_fifo
	task automatic auto_go(input logic [15:0] c1, c2, input logic [119:0] v, input int k);
		wr(3'h0, 16'h0000);
		wr(3'h0, c1);
		wr(3'h0, c2);
		wr(3'h1, {4'h0, v[119:108]});
		wait_upd(n);
		chk({4'h0, dac_code}, {4'h0, v[119:108]});
		for (int i = 1; i < k; i++) stb(v[119-12*i -: 12], 1'b0);
	endtask : auto_go
	task automatic t_auto;
		wr(3'h3, 16'h0010);
		wr(3'h4, 16'h0030);
		wr(3'h2, 16'h000C);
		auto_go(16'h003C, 16'h003C, 120'h018_024_030_024_018_010_01C_028_030_024, 10);
		auto_go(16'h001C, 16'h003C, {48'h024_018_010_01C, 72'h0}, 4);
		auto_go(16'h002C, 16'h002C, {60'h030_024_018_010_030, 60'h0}, 5);
		auto_go(16'h001C, 16'h001C, {48'h028_030_010_01C, 72'h0}, 4);
		wr(3'h0, 16'h001D);
		chk({15'h0, dac_power_down}, 16'h0001);
		stb(12'h01C, 1'b1);
		wr(3'h0, 16'h001C);
		chk({15'h0, dac_power_down}, 16'h0000);
		stb(12'h028, 1'b0);
		// start values outside the window land on the nearest limit
		wr(3'h1, 16'h0040);
		wait_upd(n);
		chk({4'h0, dac_code}, 16'h0030);
		wr(3'h1, 16'h0004);
		wait_upd(n);
		chk({4'h0, dac_code}, 16'h0010);
		$display("auto test done");
	endtask : t_auto
	// reset in mid-run returns outputs and registers to their reset values
	task automatic t_reset;
		@(negedge clk_sys);
		nrst = 1'b0;
		repeat (2) @(negedge clk_sys);
		nrst = 1'b1;
		chk({4'h0, dac_code}, 16'h0000);
		chk({15'h0, dac_power_down}, 16'h0001);
		rd(3'h0, 16'h0001);
		rd(3'h1, 16'h0000);
		rd(3'h4, 16'h0FFF);
		$display("reset test done");
	endtask : t_reset
	// hang guard
	always @(posedge clk_sys) begin
		cyc++;
		if (cyc == 5000) begin
			fails++;
			summarize();
		end
	end
	// main sequence
	initial begin
		{nrst, reg_sel, reg_wr, reg_rd, fire} = 5'h00;
		{reg_addr, reg_wdata, hi_len} = {3'h0, 16'h0000, 4'h2};
		repeat (2) @(negedge clk_sys);
		nrst = 1'b1;
		t_regs();
		t_async();
		t_fifo();
		t_auto();
		t_reset();
		summarize();
	end
endmodule : dwc_dac_ctrl_bench
`default_nettype wire
